// ---- flash_link_defs.svh ----
// Constants for the flash programming serial link block
// Behaviour
// - Asynchronous link runs only at 9600, 19200, 31250, 38400, 76800 or 153600 bps.
// - Clocked serial clock lies between 2.4 kHz and 2.5 MHz in both clocked modes.
// - Clocked modes shift each byte most significant bit first, both directions.
// - Programmer generates the transfer clock; device is slave on the received clock.
// - Handshake mode: device drives handshake pin as programmer flow-control input.
// - Mode chosen by strobe pulse count, at most 11, decoded by the device.
// - Programmer starts every exchange with a command; device answers with a response.
`ifndef FLASH_LINK_DEFS_SVH
`define FLASH_LINK_DEFS_SVH

`define CLK_FREQ_HZ        125000000
`define MAX_STROBE_PULSES  11
// Pulse counts that select the clocked link modes; any other nonzero count selects async
`define PULSES_ASYNC       4'h0
`define PULSES_CLOCKED     4'h8
`define PULSES_CLOCKED_HS  4'h9
// Strobe quiet time that closes the pulse count, in microseconds
`define STROBE_QUIET_US    100
`define STROBE_QUIET_CYC   ((`CLK_FREQ_HZ / 1000000) * `STROBE_QUIET_US)
// Supported asynchronous bit rates
`define BAUD_9600          9600
`define BAUD_19200         19200
`define BAUD_31250         31250
`define BAUD_38400         38400
`define BAUD_76800         76800
`define BAUD_153600        153600
// Slowest and fastest legal serial clock, in hertz
`define SCK_MIN_HZ         2400
`define SCK_MAX_HZ         2500000
`define SCK_MAX_HALF_CYC   ((`CLK_FREQ_HZ / `SCK_MIN_HZ) / 2)
`define BIT_CNT_W          16

`endif

// ---- flash_link_pkg.sv ----
// Types shared by the flash programming serial link
package flash_link_pkg;
  typedef enum logic [1:0] {
    MODE_NONE,
    MODE_ASYNC,
    MODE_CLOCKED,
    MODE_CLOCKED_HS
  } link_mode_t;

  typedef enum logic [2:0] {
    BR_9600,
    BR_19200,
    BR_31250,
    BR_38400,
    BR_76800,
    BR_153600
  } baud_sel_t;
endpackage : flash_link_pkg

// ---- clocked_serial_port.sv ----
// Clocked serial slave shifter running on the programmer's serial clock
`timescale 1ns/100ps
module clocked_serial_port
  import flash_link_pkg::*;
(
  input  wire logic       sck_i,
  input  wire logic       resetn_i,
  input  wire logic       serial_in_pin_i,
  input  wire logic [7:0] tx_byte_i,
  input  wire logic       tx_tog_i,
  output logic            serial_out_pin_o,
  output logic [7:0]      rx_byte_o,
  output logic            rx_tog_o,
  output logic            tx_ack_tog_o
);
  logic [7:0] rx_shift_ff;
  logic [2:0] bit_cnt_ff;
  logic [7:0] tx_shift_ff;
  logic       tx_seen_ff;

  // ***************************************
  // Receive on rising edge
  // ***************************************
  // slave on sck
  always_ff @(posedge sck_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rx_shift_ff  <= 8'h00;
      bit_cnt_ff   <= 3'h0;
      rx_byte_o    <= 8'h00;
      rx_tog_o     <= 1'b0;
    end else begin
      rx_shift_ff <= {rx_shift_ff[6:0], serial_in_pin_i};
      bit_cnt_ff  <= bit_cnt_ff + 3'h1;
      if (bit_cnt_ff == 3'h7) begin
        rx_byte_o <= {rx_shift_ff[6:0], serial_in_pin_i};
        rx_tog_o  <= ~rx_tog_o;
      end
    end
  end

  // ***************************************
  // Transmit on falling edge
  // ***************************************
  // The tx toggle is sampled only at byte boundaries, on the first falling edge of each byte.
  always_ff @(negedge sck_i or negedge resetn_i) begin
    if (!resetn_i) begin
      tx_shift_ff      <= 8'h00;
      serial_out_pin_o <= 1'b1;
      tx_seen_ff       <= 1'b0;
      tx_ack_tog_o     <= 1'b0;
    end else if (bit_cnt_ff == 3'h0) begin
      if (tx_seen_ff != tx_tog_i) begin
        serial_out_pin_o <= tx_byte_i[7];
        tx_shift_ff      <= {tx_byte_i[6:0], 1'b0};
        tx_seen_ff       <= tx_tog_i;
        tx_ack_tog_o     <= ~tx_ack_tog_o;
      end else begin
        serial_out_pin_o <= 1'b1;
        tx_shift_ff      <= 8'hff;
      end
    end else begin
      serial_out_pin_o <= tx_shift_ff[7];
      tx_shift_ff      <= {tx_shift_ff[6:0], 1'b1};
    end
  end
endmodule : clocked_serial_port

// ---- flash_programming_serial_port.sv ----
// Flash programming link: mode decode, async port and clocked port bridge
`timescale 1ns/100ps
`include "flash_link_defs.svh"
module flash_programming_serial_port
  import flash_link_pkg::*;
#(
  parameter int unsigned STROBE_QUIET_CYC = `STROBE_QUIET_CYC
)(
  input  wire logic       clk_i,
  input  wire logic       resetn_i,
  input  wire logic       sck_i,
  input  wire logic       program_mode_strobe_i,
  input  wire logic       program_mode_select_i,
  input  wire logic [2:0] baud_sel_i,
  input  wire logic       async_rx_pin_i,
  input  wire logic       serial_in_pin_i,
  output logic            async_tx_pin_o,
  output logic            serial_out_pin_o,
  output logic            handshake_pin_o,
  output logic            prog_mode_o,
  output logic            mode_error_o,
  output logic [1:0]      link_mode_o,
  output logic [7:0]      cmd_byte_o,
  output logic            cmd_valid_o,
  input  wire logic [7:0] resp_byte_i,
  input  wire logic       resp_valid_i,
  output logic            resp_ready_o
);
  // ***************************************
  // Pin synchronisers
  // ***************************************
  logic [1:0] strobe_sync_ff;
  logic [1:0] select_sync_ff;
  logic [1:0] arx_sync_ff;
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      strobe_sync_ff <= 2'b00;
      select_sync_ff <= 2'b00;
      arx_sync_ff    <= 2'b11;
    end else begin
      strobe_sync_ff <= {strobe_sync_ff[0], program_mode_strobe_i};
      select_sync_ff <= {select_sync_ff[0], program_mode_select_i};
      arx_sync_ff    <= {arx_sync_ff[0], async_rx_pin_i};
    end
  end
  wire logic strobe_s = strobe_sync_ff[1];
  wire logic arx_s    = arx_sync_ff[1];

  // ***************************************
  // Programming mode entry, strap caught after reset release
  // ***************************************
  logic       strap_done_ff;
  logic [1:0] strap_wait_ff;
  logic       prog_mode_ff;
  logic       mode_err_ff;
  // The strobe and select synchronisers leave reset low, so the strap is read only once they carry the pin levels.
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      strap_done_ff <= 1'b0;
      strap_wait_ff <= 2'h0;
      prog_mode_ff  <= 1'b0;
      mode_err_ff   <= 1'b0;
    end else if (!strap_done_ff) begin
      if (strap_wait_ff != 2'h2) begin
        strap_wait_ff <= strap_wait_ff + 2'h1;
      end else begin
        strap_done_ff <= 1'b1;
        prog_mode_ff  <= strobe_s & ~select_sync_ff[1];
        mode_err_ff   <= strobe_s & select_sync_ff[1];
      end
    end
  end
  assign prog_mode_o  = prog_mode_ff;
  assign mode_error_o = mode_err_ff;

  // ***************************************
  // Pulse count mode select
  // ***************************************
  link_mode_t  mode_ff;
  logic        strobe_d_ff;
  logic [3:0]  pulse_cnt_ff;
  logic [15:0] quiet_cnt_ff;
  logic        counting_ff;
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      strobe_d_ff  <= 1'b0;
      pulse_cnt_ff <= 4'h0;
      quiet_cnt_ff <= 16'h0000;
      counting_ff  <= 1'b0;
      mode_ff      <= MODE_NONE;
    end else begin
      strobe_d_ff <= strobe_s;
      if (prog_mode_ff && mode_ff == MODE_NONE) begin
        if (strobe_d_ff && !strobe_s) begin
          if (pulse_cnt_ff != 4'(`MAX_STROBE_PULSES)) begin
            pulse_cnt_ff <= pulse_cnt_ff + 4'h1;
          end
          counting_ff  <= 1'b1;
          quiet_cnt_ff <= 16'h0000;
        end else if (counting_ff && strobe_s) begin
          quiet_cnt_ff <= quiet_cnt_ff + 16'h0001;
          if (quiet_cnt_ff == 16'(STROBE_QUIET_CYC - 1)) begin
            counting_ff <= 1'b0;
            if (pulse_cnt_ff == `PULSES_CLOCKED) begin
              mode_ff <= MODE_CLOCKED;
            end else if (pulse_cnt_ff == `PULSES_CLOCKED_HS) begin
              mode_ff <= MODE_CLOCKED_HS;
            end else begin
              mode_ff <= MODE_ASYNC;
            end
          end
        end
      end
    end
  end
  assign link_mode_o = mode_ff;

  // ***************************************
  // Asynchronous port
  // ***************************************
  // supported rates only
  logic [15:0] bit_div;
  always_comb begin
    case (baud_sel_t'(baud_sel_i))
      BR_9600:   bit_div = 16'(`CLK_FREQ_HZ / `BAUD_9600);
      BR_19200:  bit_div = 16'(`CLK_FREQ_HZ / `BAUD_19200);
      BR_31250:  bit_div = 16'(`CLK_FREQ_HZ / `BAUD_31250);
      BR_38400:  bit_div = 16'(`CLK_FREQ_HZ / `BAUD_38400);
      BR_76800:  bit_div = 16'(`CLK_FREQ_HZ / `BAUD_76800);
      default:   bit_div = 16'(`CLK_FREQ_HZ / `BAUD_153600);
    endcase
  end
  wire logic async_on = (mode_ff == MODE_ASYNC);

  logic [15:0] arx_cnt_ff;
  logic [3:0]  arx_bit_ff;
  logic [7:0]  arx_sh_ff;
  logic        arx_busy_ff;
  logic        arx_done_ff;
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      arx_cnt_ff  <= 16'h0000;
      arx_bit_ff  <= 4'h0;
      arx_sh_ff   <= 8'h00;
      arx_busy_ff <= 1'b0;
      arx_done_ff <= 1'b0;
    end else begin
      arx_done_ff <= 1'b0;
      if (!arx_busy_ff) begin
        if (async_on && !arx_s) begin
          arx_busy_ff <= 1'b1;
          arx_cnt_ff  <= {1'b0, bit_div[15:1]};
          arx_bit_ff  <= 4'h0;
        end
      end else if (arx_cnt_ff != 16'h0000) begin
        arx_cnt_ff <= arx_cnt_ff - 16'h0001;
      end else begin
        arx_cnt_ff <= bit_div - 16'h0001;
        arx_bit_ff <= arx_bit_ff + 4'h1;
        if (arx_bit_ff == 4'h0 && arx_s) begin
          arx_busy_ff <= 1'b0;
        end else if (arx_bit_ff == 4'h9) begin
          arx_busy_ff <= 1'b0;
          arx_done_ff <= arx_s;
        end else if (arx_bit_ff != 4'h0) begin
          arx_sh_ff <= {arx_s, arx_sh_ff[7:1]};
        end
      end
    end
  end

  logic [15:0] atx_cnt_ff;
  logic [3:0]  atx_bit_ff;
  logic [9:0]  atx_sh_ff;
  logic        atx_busy_ff;
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      atx_cnt_ff  <= 16'h0000;
      atx_bit_ff  <= 4'h0;
      atx_sh_ff   <= 10'h3ff;
      atx_busy_ff <= 1'b0;
    end else if (!atx_busy_ff) begin
      if (async_on && resp_valid_i) begin
        atx_busy_ff <= 1'b1;
        atx_sh_ff   <= {1'b1, resp_byte_i, 1'b0};
        atx_cnt_ff  <= bit_div - 16'h0001;
        atx_bit_ff  <= 4'h0;
      end
    end else if (atx_cnt_ff != 16'h0000) begin
      atx_cnt_ff <= atx_cnt_ff - 16'h0001;
    end else begin
      atx_cnt_ff <= bit_div - 16'h0001;
      atx_sh_ff  <= {1'b1, atx_sh_ff[9:1]};
      atx_bit_ff <= atx_bit_ff + 4'h1;
      if (atx_bit_ff == 4'h9) begin
        atx_busy_ff <= 1'b0;
      end
    end
  end
  assign async_tx_pin_o = atx_sh_ff[0];

  // ***************************************
  // Clocked port and crossing
  // ***************************************
  logic [7:0] csp_rx_byte;
  logic       csp_rx_tog;
  logic       csp_ack_tog;
  logic [7:0] ctx_byte_ff;
  logic       ctx_tog_ff;
  logic       ctx_busy_ff;
  logic [2:0] rx_tog_sync_ff;
  logic [2:0] ack_sync_ff;
  wire logic  clocked_on = (mode_ff == MODE_CLOCKED) || (mode_ff == MODE_CLOCKED_HS);

  // sck range
  // Even at the fastest serial clock a byte spans hundreds of clk cycles, far more than the toggle crossing needs.
  clocked_serial_port clocked_serial_port_inst (
    .sck_i            (sck_i),
    .resetn_i         (resetn_i),
    .serial_in_pin_i  (serial_in_pin_i),
    .tx_byte_i        (ctx_byte_ff),
    .tx_tog_i         (ctx_tog_ff),
    .serial_out_pin_o (serial_out_pin_o),
    .rx_byte_o        (csp_rx_byte),
    .rx_tog_o         (csp_rx_tog),
    .tx_ack_tog_o     (csp_ack_tog)
  );

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rx_tog_sync_ff <= 3'b000;
      ack_sync_ff    <= 3'b000;
    end else begin
      rx_tog_sync_ff <= {rx_tog_sync_ff[1:0], csp_rx_tog};
      ack_sync_ff    <= {ack_sync_ff[1:0], csp_ack_tog};
    end
  end
  wire logic crx_evt = rx_tog_sync_ff[2] ^ rx_tog_sync_ff[1];
  wire logic cack    = ack_sync_ff[2] ^ ack_sync_ff[1];

  // Response byte is held stable until the shifter has picked it up.
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ctx_byte_ff <= 8'h00;
      ctx_tog_ff  <= 1'b0;
      ctx_busy_ff <= 1'b0;
    end else if (!ctx_busy_ff) begin
      if (clocked_on && resp_valid_i) begin
        ctx_byte_ff <= resp_byte_i;
        ctx_tog_ff  <= ~ctx_tog_ff;
        ctx_busy_ff <= 1'b1;
      end
    end else if (cack) begin
      ctx_busy_ff <= 1'b0;
    end
  end

  assign resp_ready_o = async_on ? ~atx_busy_ff : (clocked_on & ~ctx_busy_ff);

  // ***************************************
  // Command output and handshake pin
  // ***************************************
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cmd_byte_o  <= 8'h00;
      cmd_valid_o <= 1'b0;
    end else begin
      cmd_valid_o <= (async_on & arx_done_ff) | (clocked_on & crx_evt);
      if (async_on && arx_done_ff) begin
        cmd_byte_o <= arx_sh_ff;
      end else if (clocked_on && crx_evt) begin
        cmd_byte_o <= csp_rx_byte;
      end
    end
  end

  // Low means busy; the programmer waits while a response is pending.
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      handshake_pin_o <= 1'b1;
    end else if (mode_ff == MODE_CLOCKED_HS) begin
      handshake_pin_o <= ~ctx_busy_ff;
    end else begin
      handshake_pin_o <= 1'b1;
    end
  end
endmodule : flash_programming_serial_port

// ---- flash_link_sva.sv ----
// Checker for the flash programming link ports
`timescale 1ns/100ps
module flash_link_sva (
  input wire logic       clk_i,
  input wire logic       resetn_i,
  input wire logic       async_tx_pin_o,
  input wire logic       handshake_pin_o,
  input wire logic       prog_mode_o,
  input wire logic [1:0] link_mode_o,
  input wire logic       cmd_valid_o,
  input wire logic       resp_valid_i,
  input wire logic       resp_ready_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  hs_idle_a: assert property (link_mode_o != 2'h3 |-> handshake_pin_o)
    else $error("handshake pin left idle level");
  hs_pending_a: assert property (link_mode_o == 2'h3 && resp_valid_i && resp_ready_o |-> ##2 !handshake_pin_o)
    else $error("handshake not lowered for pending response");
  mode_hold_a: assert property (link_mode_o != 2'h0 |=> $stable(link_mode_o))
    else $error("link mode changed after decode");
  mode_prog_a: assert property (link_mode_o != 2'h0 |-> prog_mode_o)
    else $error("link mode set outside programming mode");
  cmd_pulse_a: assert property (cmd_valid_o |=> !cmd_valid_o)
    else $error("command valid longer than one cycle");
  cmd_gate_a: assert property (cmd_valid_o |-> link_mode_o != 2'h0)
    else $error("command seen with no link mode");
  ready_drop_a: assert property (resp_valid_i && resp_ready_o |=> !resp_ready_o)
    else $error("ready stayed high after accept");
  tx_start_a: assert property (link_mode_o == 2'h1 && resp_valid_i && resp_ready_o |-> ##[1:2] !async_tx_pin_o)
    else $error("no start bit after accept");
  tx_idle_a: assert property (link_mode_o != 2'h1 |-> async_tx_pin_o)
    else $error("async line active outside async mode");
endmodule : flash_link_sva

bind flash_programming_serial_port flash_link_sva flash_link_sva_inst (.clk_i, .resetn_i, .async_tx_pin_o,
  .handshake_pin_o, .prog_mode_o, .link_mode_o, .cmd_valid_o, .resp_valid_i, .resp_ready_o);

// ---- prog_model.sv ----
// Programmer model: strap pins, mode pulses, serial clock and async line
`timescale 1ns/100ps
module prog_model (
  input  wire logic serial_out_pin_i,
  input  wire logic async_tx_pin_i,
  output logic      sck_o,
  output logic      serial_in_pin_o,
  output logic      strobe_o,
  output logic      select_o,
  output logic      async_rx_pin_o,
  output logic      osc_in_o,
  output logic      osc_out_o
);
  real bit_ns = 1.0e9 / 153600.0;
  initial begin
    osc_in_o = 1'b0;
    forever #4 osc_in_o = ~osc_in_o;
  end
  assign osc_out_o = ~osc_in_o;
  task automatic set_rate(input int bps);
    bit_ns = 1.0e9 / bps;
  endtask : set_rate
  initial begin
    sck_o = 1'b1;
    serial_in_pin_o = 1'b1;
    strobe_o = 1'b0;
    select_o = 1'b0;
    async_rx_pin_o = 1'b1;
  end
  task automatic strap(input logic st, input logic sel);
    strobe_o = st;
    select_o = sel;
  endtask : strap
  task automatic pulses(input int n);
    repeat (n) begin
      #200 strobe_o = 1'b0;
      #200 strobe_o = 1'b1;
    end
  endtask : pulses
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      sck_o = 1'b0;
      serial_in_pin_o = tx[i];
      #15 sck_o = 1'b1;
      rx[i] = serial_out_pin_i;
      #15;
    end
    // Released line must not keep the last bit
    serial_in_pin_o = ~tx[0];
  endtask : xfer
  task automatic async_put(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      async_rx_pin_o = f[i];
      #(bit_ns);
    end
  endtask : async_put
  task automatic async_get(output logic [7:0] b);
    @(negedge async_tx_pin_i);
    #(bit_ns * 1.5);
    for (int i = 0; i < 8; i++) begin
      b[i] = async_tx_pin_i;
      #(bit_ns);
    end
  endtask : async_get
endmodule : prog_model

// ---- tb_flash_programming_serial_port.sv ----
// Self-checking bench for the flash programming serial link
`timescale 1ns/100ps
module tb_flash_programming_serial_port;
  logic       clk_i, resetn_i, sck, strobe, select, rx_pin, sin, tx_pin, sout, hs;
  logic       prog_mode, mode_err, cmd_valid, resp_valid_i, resp_ready;
  logic [1:0] link_mode;
  logic [7:0] cmd_byte, resp_byte_i;
  logic [2:0] baud_sel;
  int         bad_count, n_checks;

  flash_programming_serial_port #(.STROBE_QUIET_CYC(50)) flash_programming_serial_port_inst (
    .clk_i(clk_i), .resetn_i(resetn_i), .sck_i(sck), .program_mode_strobe_i(strobe),
    .program_mode_select_i(select), .baud_sel_i(baud_sel), .async_rx_pin_i(rx_pin),
    .serial_in_pin_i(sin), .async_tx_pin_o(tx_pin), .serial_out_pin_o(sout),
    .handshake_pin_o(hs), .prog_mode_o(prog_mode), .mode_error_o(mode_err),
    .link_mode_o(link_mode), .cmd_byte_o(cmd_byte), .cmd_valid_o(cmd_valid),
    .resp_byte_i(resp_byte_i), .resp_valid_i(resp_valid_i), .resp_ready_o(resp_ready));
  prog_model prog_model_inst (.serial_out_pin_i(sout), .async_tx_pin_i(tx_pin), .sck_o(sck),
    .serial_in_pin_o(sin), .strobe_o(strobe), .select_o(select), .async_rx_pin_o(rx_pin),
    .osc_in_o(), .osc_out_o());

  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end

  task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask : check

  task automatic summarize;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : summarize

  task automatic do_reset(input logic st, input logic sel, input int n);
    @(posedge clk_i);
    #1 resetn_i = 1'b0;
    prog_model_inst.strap(st, sel);
    repeat (5) @(posedge clk_i);
    #1 resetn_i = 1'b1;
    repeat (8) @(posedge clk_i);
    prog_model_inst.pulses(n);
    // Quiet window of 50 plus decode latency
    repeat (80) @(posedge clk_i);
    #1;
  endtask : do_reset

  task automatic wait_cmd(input logic [7:0] exp);
    int k;
    k = 0;
    do begin
      @(posedge clk_i);
      #1 k++;
    end while (cmd_valid !== 1'b1 && k < 20000);
    check({7'h0, cmd_valid}, 8'h01, "command valid");
    check(cmd_byte, exp, "command byte");
  endtask : wait_cmd

  task automatic send_resp(input logic [7:0] b);
    int k;
    k = 0;
    @(posedge clk_i);
    #1 resp_byte_i = b;
    resp_valid_i = 1'b1;
    // Ready is looked at where it has settled; the request is taken at the next edge.
    while (resp_ready !== 1'b1 && k < 20000) begin
      @(posedge clk_i);
      #1 k++;
    end
    check({7'h0, resp_ready}, 8'h01, "response ready");
    @(posedge clk_i);
    #1 resp_valid_i = 1'b0;
  endtask : send_resp

  // ****************
  // Scenarios
  // ****************
  task automatic t_bad_strap;
    do_reset(1'b1, 1'b1, 0);
    check({7'h0, mode_err}, 8'h01, "mode error");
    check({7'h0, prog_mode}, 8'h00, "prog mode");
  endtask : t_bad_strap

  task automatic t_hs;
    logic [7:0] r;
    do_reset(1'b1, 1'b0, 9);
    check({6'h0, link_mode}, 8'h03, "link mode");
    fork
      prog_model_inst.xfer(8'hA5, r);
      wait_cmd(8'hA5);
    join
    send_resp(8'h3C);
    repeat (2) @(posedge clk_i);
    #1 check({7'h0, hs}, 8'h00, "handshake busy");
    fork
      prog_model_inst.xfer(8'h5A, r);
      wait_cmd(8'h5A);
    join
    check(r, 8'h3C, "serial out");
    repeat (8) @(posedge clk_i);
    #1 check({7'h0, hs}, 8'h01, "handshake ready");
  endtask : t_hs

  task automatic t_plain;
    logic [7:0] r;
    do_reset(1'b1, 1'b0, 8);
    check({6'h0, link_mode}, 8'h02, "link mode");
    fork
      prog_model_inst.xfer(8'h7E, r);
      wait_cmd(8'h7E);
    join
    send_resp(8'h81);
    repeat (2) @(posedge clk_i);
    #1 check({7'h0, hs}, 8'h01, "handshake idle");
    prog_model_inst.xfer(8'h00, r);
    check(r, 8'h81, "serial out");
  endtask : t_plain

  task automatic t_async;
    logic [7:0] r;
    do_reset(1'b1, 1'b0, 3);
    check({6'h0, link_mode}, 8'h01, "link mode");
    fork
      prog_model_inst.async_put(8'hC3);
      wait_cmd(8'hC3);
    join
    fork
      send_resp(8'h96);
      prog_model_inst.async_get(r);
    join
    check(r, 8'h96, "async out");
    check({7'h0, hs}, 8'h01, "handshake idle");
  endtask : t_async

  task automatic t_async_slow;
    logic [7:0] r;
    baud_sel = 3'h4;
    prog_model_inst.set_rate(76800);
    do_reset(1'b1, 1'b0, 5);
    check({6'h0, link_mode}, 8'h01, "link mode other count");
    fork
      prog_model_inst.async_put(8'h3A);
      wait_cmd(8'h3A);
    join
    fork
      send_resp(8'h69);
      prog_model_inst.async_get(r);
    join
    check(r, 8'h69, "async out slow");
  endtask : t_async_slow

  initial begin
    resetn_i = 1'b0;
    resp_byte_i = 8'h00;
    resp_valid_i = 1'b0;
    baud_sel = 3'h5;
    bad_count = 0;
    n_checks = 0;
    t_bad_strap;
    t_hs;
    t_plain;
    t_async;
    t_async_slow;
    summarize;
  end

  // Whole run needs about 395 us
  initial begin
    #600000;
    bad_count++;
    summarize;
  end
endmodule : tb_flash_programming_serial_port
